/* File: design/mcpwm_regs.svh */
`ifndef MCPWM_REGS_SVH
`define MCPWM_REGS_SVH
`define MCPWM_NUM_SLAVES 3
`define MCPWM_CNT_WIDTH 16
`define MCPWM_CNT_ZERO 16'h0000
`define MCPWM_CNT_HALT 16'hffff
`define MCPWM_DATA_RESET 16'hffff
`define MCPWM_SPLIT_MASK 16'h00ff
`endif

/* File: design/mcpwm_pkg.sv */
package mcpwm_pkg;
	typedef logic [15:0] mcpwm_cnt_t;
	typedef enum logic [1:0] {
		MCPWM_IDLE = 2'b00,
		MCPWM_RUN = 2'b01
	} mcpwm_state_e;
	typedef struct packed {
		logic out_en;
		logic out_level;
		logic polarity;
		logic slave_mode;
		logic split;
	} mcpwm_slave_cfg_s;
endpackage

/* File: design/mcpwm_timer.sv */
// Functional notes
// - master reloads period, counts down, irq at zero, reloads, repeats.
// - output period is period data plus one count clocks.
// - slave duty equals duty data over period data plus one.
// - duty data above period plus one saturates to full duty.
// - slave loads duty data on master irq, counts down to zero.
// - slave at zero raises irq and halts at ffff until retrigger.
// - pwm goes active one count clock after master irq, inactive at zero.
// - channel 0 is master, up to three slave outputs.
// - slaves are channels 1..3 above the master.
// - split channels 1 or 3 use only the low 8-bit half.
// - period data reaches its counter at start and master irq, duty data only at master irq.
// - with output enable low the written level drives the pin.
// - after handover the port keeps the pin level.
// - unit enable low stops clock and resets all state.
// - polarity 0 active high, 1 active low.
// - output mode 1 makes the channel a slave pwm output.
`timescale 1ns/10ps
`default_nettype none
`include "mcpwm_regs.svh"
module mcpwm_timer
	import mcpwm_pkg::*;
#(
	parameter int NS = `MCPWM_NUM_SLAVES
) (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic CLK_EN,
	input wire logic UNIT_ENABLE_BIT,
	input wire logic COUNT_TICK,
	input wire logic CHANNEL_START_TRIG,
	input wire logic CHANNEL_STOP_TRIG,
	input wire logic [15:0] PERIOD_DATA_REG,
	input wire logic [NS*16-1:0] DUTY_DATA_REG,
	input wire mcpwm_slave_cfg_s [NS-1:0] SLAVE_CFG,
	output logic CHANNEL_RUN_STATUS,
	output logic [15:0] PERIOD_COUNTER,
	output logic [NS*16-1:0] DUTY_COUNTER,
	output logic PERIOD_END_IRQ,
	output logic [NS-1:0] DUTY_END_IRQ,
	output logic [NS-1:0] PWM_OUT
);

// ==========================================================
// helpers
// ==========================================================
function automatic mcpwm_cnt_t slave_load(input mcpwm_cnt_t d,
		input logic split_ch);
	// split channels 1 and 3 keep only the lower 8-bit half
	if (split_ch) begin
		slave_load = d & `MCPWM_SPLIT_MASK;
	end else begin
		slave_load = d;
	end
endfunction

function automatic logic split_allowed(input int idx);
	// slave index i is channel i+1; channels 1 and 3 may split
	split_allowed = (idx == 0) || (idx == 2);
endfunction

function automatic logic is_zero(input mcpwm_cnt_t c);
	// terminal count test shared by master and slaves
	is_zero = (c == `MCPWM_CNT_ZERO);
endfunction

// ==========================================================
// master channel
// ==========================================================
mcpwm_state_e state_ff;
logic run;
logic tick;
logic master_zero;
logic master_irq;

assign run = (state_ff == MCPWM_RUN) && UNIT_ENABLE_BIT;
assign tick = CLK_EN && UNIT_ENABLE_BIT && COUNT_TICK;
assign master_zero = is_zero(PERIOD_COUNTER);
assign master_irq = run && tick && master_zero;

// ==========================================================
// run state
// ==========================================================
mcpwm_state_e nxt_state;

always_comb begin
	nxt_state = state_ff;
	case (state_ff)
	MCPWM_IDLE: begin
		if (CHANNEL_START_TRIG) begin
			nxt_state = MCPWM_RUN;
		end
	end
	MCPWM_RUN: begin
		if (CHANNEL_STOP_TRIG) begin
			nxt_state = MCPWM_IDLE;
		end
	end
	default: begin
		nxt_state = MCPWM_IDLE;
	end
	endcase
	// unit enable low forces the idle state
	if (!UNIT_ENABLE_BIT) begin
		nxt_state = MCPWM_IDLE;
	end
end

always_ff @(posedge CLK or negedge RESET_N) begin
	if (!RESET_N) begin
		state_ff <= MCPWM_IDLE;
	end else if (CLK_EN) begin
		state_ff <= nxt_state;
	end
end

// status is written with the same next state as the state register
always_ff @(posedge CLK or negedge RESET_N) begin
	if (!RESET_N) begin
		CHANNEL_RUN_STATUS <= 1'b0;
	end else if (CLK_EN) begin
		CHANNEL_RUN_STATUS <= (nxt_state == MCPWM_RUN);
	end
end

// ==========================================================
// period counter: load at start, reload at zero
// ==========================================================
always_ff @(posedge CLK or negedge RESET_N) begin
	if (!RESET_N) begin
		PERIOD_COUNTER <= `MCPWM_CNT_ZERO;
	end else if (CLK_EN) begin
		if (!UNIT_ENABLE_BIT) begin
			PERIOD_COUNTER <= `MCPWM_CNT_ZERO;
		end else if (state_ff == MCPWM_IDLE && CHANNEL_START_TRIG) begin
			PERIOD_COUNTER <= PERIOD_DATA_REG;
		end else if (run && tick) begin
			if (master_zero) begin
				PERIOD_COUNTER <= PERIOD_DATA_REG;
			end else begin
				PERIOD_COUNTER <= PERIOD_COUNTER - 16'h0001;
			end
		end
	end
end

// ==========================================================
// period interrupt: one-cycle pulse at the terminal count
// ==========================================================
always_ff @(posedge CLK or negedge RESET_N) begin
	if (!RESET_N) begin
		PERIOD_END_IRQ <= 1'b0;
	end else if (CLK_EN) begin
		PERIOD_END_IRQ <= master_irq;
	end
end

// ==========================================================
// slave channels 1..NS
// ==========================================================
// one flop set per slave; unpacked so each slave owns its own element
mcpwm_cnt_t duty_cnt_ff [NS];
logic duty_irq_ff [NS];
logic pwm_ff [NS];

// pack the per-slave flops onto the output ports
always_comb begin
	for (int i = 0; i < NS; i++) begin
		DUTY_COUNTER[i*16 +: 16] = duty_cnt_ff[i];
		DUTY_END_IRQ[i] = duty_irq_ff[i];
		PWM_OUT[i] = pwm_ff[i];
	end
end

genvar g;
generate
for (g = 0; g < NS; g++) begin : g_slave
	logic active_ff;
	logic level_now;
	logic load_now;
	logic step_now;
	logic at_zero;
	mcpwm_cnt_t duty;
	mcpwm_cnt_t load_val;
	mcpwm_slave_cfg_s cfg;

	// ======================================================
	// slave controls
	// ======================================================
	assign duty = DUTY_DATA_REG[g*16 +: 16];
	assign cfg = SLAVE_CFG[g];
	assign at_zero = is_zero(duty_cnt_ff[g]);
	assign load_val = slave_load(duty,
		cfg.split && split_allowed(g));

	// retrigger on the master terminal count while in slave output mode
	assign load_now = UNIT_ENABLE_BIT && cfg.slave_mode && master_irq;
	// count only when armed and no retrigger wins this tick
	assign step_now = UNIT_ENABLE_BIT && cfg.slave_mode && !master_irq
		&& run && tick && active_ff;

	// ======================================================
	// slave counter: load on master irq, count to zero, park
	// ======================================================
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			duty_cnt_ff[g] <= `MCPWM_CNT_HALT;
		end else if (CLK_EN) begin
			if (!UNIT_ENABLE_BIT) begin
				duty_cnt_ff[g] <= `MCPWM_CNT_HALT;
			end else if (load_now) begin
				duty_cnt_ff[g] <= load_val;
			end else if (step_now) begin
				if (at_zero) begin
					duty_cnt_ff[g] <= `MCPWM_CNT_HALT;
				end else begin
					duty_cnt_ff[g] <= duty_cnt_ff[g] - 16'h0001;
				end
			end
		end
	end

	// ======================================================
	// slave end-of-duty interrupt
	// ======================================================
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			duty_irq_ff[g] <= 1'b0;
		end else if (CLK_EN) begin
			duty_irq_ff[g] <= step_now && at_zero;
		end
	end

	// ======================================================
	// slave armed flag
	// ======================================================
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			active_ff <= 1'b0;
		end else if (CLK_EN) begin
			if (!UNIT_ENABLE_BIT) begin
				active_ff <= 1'b0;
			end else if (!cfg.slave_mode) begin
				active_ff <= 1'b0;
			end else if (load_now) begin
				active_ff <= 1'b1;
			end else if (step_now && at_zero) begin
				active_ff <= 1'b0;
			end
		end
	end

	// active from the tick after load until zero; zero duty is at zero
	// on its first tick, so it never shows active
	assign level_now = active_ff && !at_zero
		&& (duty_cnt_ff[g] != `MCPWM_CNT_HALT
		|| duty == `MCPWM_CNT_HALT);

	// ======================================================
	// slave pin: counted waveform when enabled, else written level
	// ======================================================
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			pwm_ff[g] <= 1'b0;
		end else if (CLK_EN) begin
			if (!UNIT_ENABLE_BIT) begin
				pwm_ff[g] <= 1'b0;
			end else if (!cfg.out_en) begin
				pwm_ff[g] <= cfg.out_level;
			end else if (cfg.slave_mode && run && tick) begin
				pwm_ff[g] <= level_now ^ cfg.polarity;
			end
		end
	end
end
endgenerate

endmodule
`default_nettype wire

/* File: verification/mcpwm_timer_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module mcpwm_timer_sva import mcpwm_pkg::*; #(parameter int NS = 3) (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic CLK_EN,
	input wire logic UNIT_ENABLE_BIT,
	input wire logic COUNT_TICK,
	input wire logic [15:0] PERIOD_DATA_REG,
	input wire logic [NS*16-1:0] DUTY_DATA_REG,
	input wire mcpwm_slave_cfg_s [NS-1:0] SLAVE_CFG,
	input wire logic CHANNEL_RUN_STATUS,
	input wire logic [15:0] PERIOD_COUNTER,
	input wire logic [NS*16-1:0] DUTY_COUNTER,
	input wire logic PERIOD_END_IRQ,
	input wire logic [NS-1:0] DUTY_END_IRQ,
	input wire logic [NS-1:0] PWM_OUT
);
	// ====================
	// slave 0 and master
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	property p_irq; PERIOD_END_IRQ && $past(CLK_EN)
		|-> $past(PERIOD_COUNTER) == 16'h0000; endproperty
	a_irq: assert property (p_irq) else $error("irq");
	property p_rld; PERIOD_END_IRQ && $past(CLK_EN)
		|-> PERIOD_COUNTER == $past(PERIOD_DATA_REG); endproperty
	a_rld: assert property (p_rld) else $error("reload");
	property p_sld;
		PERIOD_END_IRQ && $past(CLK_EN) && $past(SLAVE_CFG[0].slave_mode)
		&& !$past(SLAVE_CFG[0].split)
		|-> DUTY_COUNTER[15:0] == $past(DUTY_DATA_REG[15:0]);
	endproperty
	a_sld: assert property (p_sld) else $error("slave load");
	property p_hlt; DUTY_END_IRQ[0] |-> DUTY_COUNTER[15:0] == 16'hffff; endproperty
	a_hlt: assert property (p_hlt) else $error("halt");
	property p_act;
		PERIOD_END_IRQ && COUNT_TICK && CLK_EN && SLAVE_CFG[0].out_en &&
		UNIT_ENABLE_BIT && SLAVE_CFG[0].slave_mode &&
		DUTY_COUNTER[15:0] != 16'h0000 |=> PWM_OUT[0] != SLAVE_CFG[0].polarity;
	endproperty
	a_act: assert property (p_act) else $error("active");
	property p_ina;
		DUTY_END_IRQ[0] && $past(CLK_EN) && $past(SLAVE_CFG[0].out_en)
		|-> PWM_OUT[0] == $past(SLAVE_CFG[0].polarity);
	endproperty
	a_ina: assert property (p_ina) else $error("inactive");
	property p_lvl; CLK_EN && UNIT_ENABLE_BIT && !SLAVE_CFG[0].out_en
		|=> PWM_OUT[0] == $past(SLAVE_CFG[0].out_level); endproperty
	a_lvl: assert property (p_lvl) else $error("level");
	property p_off; !UNIT_ENABLE_BIT && CLK_EN
		|=> !CHANNEL_RUN_STATUS && PWM_OUT == '0; endproperty
	a_off: assert property (p_off) else $error("unit off");
	cover property (PERIOD_END_IRQ);
	cover property (DUTY_END_IRQ[0]);
	cover property (!UNIT_ENABLE_BIT);
endmodule
bind mcpwm_timer mcpwm_timer_sva #(.NS(NS)) u_sva (.CLK(CLK), .RESET_N(RESET_N),
	.CLK_EN(CLK_EN), .UNIT_ENABLE_BIT(UNIT_ENABLE_BIT), .COUNT_TICK(COUNT_TICK),
	.PERIOD_DATA_REG(PERIOD_DATA_REG), .DUTY_DATA_REG(DUTY_DATA_REG),
	.SLAVE_CFG(SLAVE_CFG), .CHANNEL_RUN_STATUS(CHANNEL_RUN_STATUS),
	.PERIOD_COUNTER(PERIOD_COUNTER), .DUTY_COUNTER(DUTY_COUNTER),
	.PERIOD_END_IRQ(PERIOD_END_IRQ), .DUTY_END_IRQ(DUTY_END_IRQ), .PWM_OUT(PWM_OUT));
`default_nettype wire

/* File: verification/mcpwm_timer_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module mcpwm_timer_tb_top import mcpwm_pkg::*;;
	logic clk = 1'b0, rst_n = 1'b0, ue = 1'b1, st = 1'b0, run, pirq;
	logic tk = 1'b1, slow = 1'b0;
	logic [15:0] per = 16'h0003, pcnt, n;
	logic [47:0] duty = {16'h0300, 16'h0009, 16'h0002}, dcnt;
	mcpwm_slave_cfg_s [2:0] cfg = {5'b10011, 5'b10010, 5'b10010};
	logic [2:0] dirq, pwm;
	logic [15:0] h [3];
	int n_errors = 0, n_tests = 0;
	always #10 clk = ~clk;
	// count clock: every cycle, or every other cycle in the slow phase
	always @(posedge clk) tk <= slow ? ~tk : 1'b1;
	mcpwm_timer u_dut (.CLK(clk), .RESET_N(rst_n), .CLK_EN(1'b1),
		.UNIT_ENABLE_BIT(ue), .COUNT_TICK(tk), .CHANNEL_START_TRIG(st),
		.CHANNEL_STOP_TRIG(1'b0), .PERIOD_DATA_REG(per), .DUTY_DATA_REG(duty),
		.SLAVE_CFG(cfg), .CHANNEL_RUN_STATUS(run), .PERIOD_COUNTER(pcnt),
		.DUTY_COUNTER(dcnt), .PERIOD_END_IRQ(pirq), .DUTY_END_IRQ(dirq),
		.PWM_OUT(pwm));
	// ====================
	// tasks
	task chk(input logic [15:0] g, e);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("Error %0t got %h exp %h", $time, g, e);
		end
	endtask
	task complete_run;
		if (n_errors == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// cycles to next period end, and high cycles of each pin meanwhile
	task meas;
		n = 0;
		h = '{0, 0, 0};
		do begin
			@(negedge clk);
			n++;
			foreach (h[i]) h[i] += pwm[i];
		end while (!pirq && n < 50);
	endtask
	task period3;
		repeat (3) meas();
	endtask
	initial begin
		#100us;
		n_errors++;
		complete_run();
	end
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		st <= 1'b1;
		@(posedge clk);
		st <= 1'b0;
		period3();
		chk(n, 4);
		chk(h[0], 2);
		chk(h[1], 4);
		chk(h[2], 0);
		@(posedge clk);
		per <= 16'h0005;
		duty[15:0] <= 16'h0003;
		@(negedge clk);
		chk(pcnt, 16'h0002);
		repeat (2) meas();
		chk(n, 6);
		chk(h[0], 3);
		@(posedge clk);
		slow <= 1'b1;
		repeat (2) meas();
		chk(n, 12);
		chk(h[0], 6);
		@(posedge clk);
		slow <= 1'b0;
		cfg[1] <= 5'b10110;
		period3();
		chk(h[1], 0);
		@(posedge clk);
		cfg[0] <= 5'b01010;
		repeat (2) @(negedge clk);
		chk(pwm[0], 1);
		@(posedge clk);
		cfg[0] <= 5'b00010;
		repeat (2) @(negedge clk);
		chk(pwm[0], 0);
		@(posedge clk);
		ue <= 1'b0;
		repeat (2) @(negedge clk);
		chk({run, pwm, pcnt[11:0]}, 0);
		chk(dcnt[15:0], 16'hffff);
		complete_run();
	end
endmodule
`default_nettype wire
